// [rtl/gdrv_defines.svh]
`ifndef GDRV_DEFINES_SVH
`define GDRV_DEFINES_SVH
// Clock period and counter width
`define CLK_PERIOD_NS 4
`define TMR_W 24
// Register byte offsets
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define MODE_OFS 8'h08
// Control register field positions
`define CTRL_CLR 0
`define CTRL_WREP 1
`define CTRL_GDIS 2
`define CTRL_SDIS 3
`define CTRL_SEL 4
`define CTRL_TRIP 8
// Reset values and fixed settings of the pin-configured variant
`define SEL_RST 2'h0
`define TRIP_RST 8'h80
`define HW_TRIP_CODE 8'h80
`define HW_SEL 2'h1
// Times in ns
`define DEGLITCH_NS 4000
`define GATE_TIMEOUT_NS 4000
`define RETRY_NS 4000000
`define SLEEP_NS 100000
`define WAKE_NS 1000000
`define RST_WIN_NS 20000
// Least times round up, longest times round down
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DN(ns) ((ns) / `CLK_PERIOD_NS)
`endif

// [rtl/gdrv_pkg.sv]
package gdrv_pkg;
	// Power modes, one-hot
	typedef enum logic [3:0] {
		MODE_SLEEP = 4'h1,
		MODE_WAKING = 4'h2,
		MODE_OPER = 4'h4,
		MODE_SHUTDOWN = 4'h8
	} mode_t;
	// Register decode result
	typedef enum logic [1:0] {
		RS_CTRL = 2'h0,
		RS_STAT = 2'h1,
		RS_MODE = 2'h2,
		RS_NONE = 2'h3
	} reg_sel_t;
	// Software configuration
	typedef struct packed {
		logic [7:0] trip;
		logic [1:0] sel;
		logic sen_dis;
		logic gdf_dis;
		logic warn_rep;
	} cfg_t;
	// Fault and status flags
	typedef struct packed {
		logic [5:0] gate_voltage_flags;
		logic [2:0] phase_oc;
		logic uvlo;
		logic warn;
		logic tsd_flag;
		logic tsd_active;
		logic gate_drive_fault;
		logic sense_oc;
		logic sense_stop;
	} flags_t;
endpackage : gdrv_pkg

// [rtl/deglitch_timer.sv]
`timescale 1ns/1ps
`include "gdrv_defines.svh"
module deglitch_timer
	import gdrv_pkg::*;
#(
	parameter int unsigned LIMIT = 1
) (
	input wire logic clock, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic cond, // Condition under watch
	output logic hit // Condition held longer than LIMIT cycles
);
	// Counter plus flag
	typedef struct packed {
		logic [`TMR_W-1:0] cnt;
		logic hit;
	} tmr_t;
	tmr_t state;
	tmr_t next_state;

	// Any gap in the condition restarts the count
	always_comb
	begin
		next_state = state;
		if (!cond)
		begin
			next_state = '0;
		end
		else if (state.cnt == LIMIT[`TMR_W-1:0])
		begin
			next_state.hit = 1'b1;
		end
		else
		begin
			next_state.cnt = state.cnt + `TMR_W'(1);
		end
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (srst)
			state <= '0;
		else
			state <= next_state;
	end

	assign hit = state.hit;
endmodule : deglitch_timer

// [rtl/enable_monitor.sv]
`timescale 1ns/1ps
`include "gdrv_defines.svh"
module enable_monitor
	import gdrv_pkg::*;
#(
	parameter int unsigned RST_WIN = 1,
	parameter int unsigned SLEEP_CYC = 1,
	parameter int unsigned WAKE_CYC = 1
) (
	input wire logic clock, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic enable, // Effective enable level
	output logic rst_pulse, // Short low pulse seen, one cycle
	output logic past_win, // Low longer than the reset window
	output logic sleep_due, // Low for the sleep delay
	output logic wake_done // High for the wake delay
);
	typedef struct packed {
		logic en_q;
		logic [`TMR_W-1:0] low_cnt;
		logic [`TMR_W-1:0] high_cnt;
		logic pulse;
		logic past_win;
		logic sleep_due;
		logic wake_done;
	} mon_t;
	mon_t state;
	mon_t next_state;

	// Low and high time measurement, saturating
	always_comb
	begin
		next_state = state;
		next_state.en_q = enable;
		next_state.pulse = 1'b0;
		if (enable)
		begin
			next_state.low_cnt = '0;
			next_state.past_win = 1'b0;
			next_state.sleep_due = 1'b0;
			// Rising edge ends a pulse only inside the window
			next_state.pulse = !state.en_q && !state.past_win;
			if (!state.wake_done)
				next_state.high_cnt = state.high_cnt + `TMR_W'(1);
			next_state.wake_done = (state.high_cnt >= WAKE_CYC[`TMR_W-1:0]);
		end
		else
		begin
			next_state.high_cnt = '0;
			next_state.wake_done = 1'b0;
			if (!state.sleep_due)
				next_state.low_cnt = state.low_cnt + `TMR_W'(1);
			next_state.past_win = (state.low_cnt >= RST_WIN[`TMR_W-1:0]);
			next_state.sleep_due = (state.low_cnt >= SLEEP_CYC[`TMR_W-1:0]);
		end
	end

	// State register; enable assumed high out of reset
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state <= '0;
			state.en_q <= 1'b1;
		end
		else
			state <= next_state;
	end

	assign rst_pulse = state.pulse;
	assign past_win = state.past_win;
	assign sleep_due = state.sleep_due;
	assign wake_done = state.wake_done;
endmodule : enable_monitor

// [rtl/gate_driver_fault_and_mode_ctrl.sv]
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "gdrv_defines.svh"
// Behaviour
// - Sense trip needs level held past deglitch
// - Pin variant: fixed 1 V, 4 us, retry
// - Serial variant: trip level, four responses
// - Mode 00: stop, latch until clear
// - Mode 01: stop, release after retry interval
// - Mode 10: report only, latch until clear
// - Mode 11 or disable bit: ignore sense
// - Gate not slewed before timeout flags fault
// - Gate fault stops drive, latches flags
// - Gate fault needs clear and condition gone
// - Gate fault disable suppresses it entirely
// - Thermal warning flag with hysteresis, no action
// - Warning reaches fault pin when report set
// - Thermal shutdown stops drive and charge pump
// - Shutdown flag sticky until clear, always on
// - Enable low past sleep delay: sleep
// - Enable high wakes; inputs after wake delay
// - Sleep or undervoltage: gates pulled off
// - Fault pin low during power transitions
// - Operating mode latches hardware configuration
// - Floating enable counts as high
// - Clear by bit or short enable pulse
// - Enable pulse clears only latched faults
// - Summary flag is OR, mirrors pin
module gate_driver_fault_and_mode_ctrl
	import gdrv_pkg::*;
#(
	parameter int unsigned RETRY_CYC = `CYC_UP(`RETRY_NS),
	parameter int unsigned SLEEP_CYC = `CYC_UP(`SLEEP_NS),
	parameter int unsigned WAKE_CYC = `CYC_DN(`WAKE_NS),
	parameter int unsigned RST_WIN_CYC = `CYC_DN(`RST_WIN_NS)
) (
	input wire logic clock, // 250 MHz clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic [7:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic enable_pin, // Enable pin level
	input wire logic enable_float, // Enable pin undriven
	input wire logic variant_strap, // High for pin-configured variant
	input wire logic vm_uvlo, // Supply undervoltage
	input wire logic [2:0][7:0] sense_sample, // Sense input per phase
	input wire logic [5:0] gate_cmd, // Commanded gate states
	input wire logic [5:0] gate_level, // Observed gate states
	input wire logic temp_warn_over, // Above warning trip
	input wire logic temp_warn_under_hys, // Below warning hysteresis
	input wire logic temp_sd_over, // Above shutdown trip
	input wire logic temp_sd_under_hys, // Below shutdown hysteresis
	output logic [5:0] gate_drive, // Gate drive outputs
	output logic gate_pulls, // Internal gate pull resistors on
	output logic charge_pump_en, // Charge pump enable
	output logic logic_regulator_en, // Logic regulator enable
	output logic serial_en, // Register port active
	output logic inputs_ready, // Inputs accepted
	output logic fault_out_n, // Fault pin, active low
	output logic fault_summary // Summary fault flag
);
	localparam int unsigned DEG_CYC = `CYC_UP(`DEGLITCH_NS);
	localparam int unsigned GATE_CYC = `CYC_UP(`GATE_TIMEOUT_NS);

	// Whole block state
	typedef struct packed {
		mode_t mode;
		cfg_t cfg;
		flags_t flg;
		logic hw_variant;
		logic retry_run;
		logic [`TMR_W-1:0] retry_cnt;
		logic [5:0] gate_drive;
		logic drive_en;
		logic cp_en;
		logic reg_en;
		logic serial_en;
		logic pulls;
		logic fault_n;
		logic summary;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_t;
	state_t state;
	state_t next_state;

	logic enable_eff; // Enable after float handling
	logic mon_pulse; // Short enable pulse
	logic mon_past_win; // Enable low too long for a pulse
	logic mon_sleep; // Sleep delay reached
	logic mon_wake; // Wake delay reached
	logic [2:0] sense_hit_v; // Per-phase sense trips
	logic [5:0] gate_hit_v; // Per-gate timeouts
	logic sense_hit; // Any sense trip
	logic hw; // Pin variant
	logic [7:0] trip_eff; // Trip level in use
	logic [1:0] sel_eff; // Response in use
	logic sense_off; // Sense response off
	logic gdf_off; // Gate fault detection off
	logic clear; // Fault clear request
	logic apb_wr; // Write taking effect
	logic reported; // Any reported fault

	// Register address decode
	function automatic reg_sel_t reg_sel(input logic [7:0] a);
		case (a)
			`CTRL_OFS: reg_sel = RS_CTRL;
			`STAT_OFS: reg_sel = RS_STAT;
			`MODE_OFS: reg_sel = RS_MODE;
			default: reg_sel = RS_NONE;
		endcase
	endfunction : reg_sel

	// Undriven enable pin is pulled high internally
	assign enable_eff = enable_pin || enable_float;
	assign hw = state.hw_variant;
	// Pin variant ignores software settings
	assign trip_eff = hw ? `HW_TRIP_CODE : state.cfg.trip;
	assign sel_eff = hw ? `HW_SEL : state.cfg.sel;
	assign sense_off = (sel_eff == 2'h3) || (!hw && state.cfg.sen_dis);
	assign gdf_off = !hw && state.cfg.gdf_dis;
	assign sense_hit = |sense_hit_v;
	assign apb_wr = psel && penable && state.pready && pwrite;

	// Enable pin timing: pulse, window, sleep and wake delays
	enable_monitor #(
		.RST_WIN(RST_WIN_CYC),
		.SLEEP_CYC(SLEEP_CYC),
		.WAKE_CYC(WAKE_CYC)
	) u_enable_monitor (
		.clock(clock),
		.srst(srst),
		.enable(enable_eff),
		.rst_pulse(mon_pulse),
		.past_win(mon_past_win),
		.sleep_due(mon_sleep),
		.wake_done(mon_wake)
	);

	// Sense deglitch per phase, only while operating
	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_sense
			deglitch_timer #(
				.LIMIT(DEG_CYC)
			) u_sense_deg (
				.clock(clock),
				.srst(srst),
				.cond(state.mode == MODE_OPER && !sense_off && sense_sample[i] > trip_eff),
				.hit(sense_hit_v[i])
			);
		end
		// Gate slew watchdog per gate, only while driving
		for (genvar j = 0; j < 6; j++)
		begin : g_gate
			deglitch_timer #(
				.LIMIT(GATE_CYC)
			) u_gate_tmo (
				.clock(clock),
				.srst(srst),
				.cond(state.drive_en && !gdf_off && state.gate_drive[j] != gate_level[j]),
				.hit(gate_hit_v[j])
			);
		end
	endgenerate

	// Next state: bus, faults, modes and outputs
	always_comb
	begin
		next_state = state;
		clear = mon_pulse;
		// Zero-wait answer: ready during every access phase
		next_state.pready = psel && !penable;
		next_state.pslverr = psel && !penable && reg_sel(paddr) == RS_NONE;
		next_state.prdata = 32'h0000_0000;
		if (psel && !penable)
		begin
			case (reg_sel(paddr))
				RS_CTRL: next_state.prdata = {16'h0000, state.cfg.trip, 2'h0, state.cfg.sel,
					state.cfg.sen_dis, state.cfg.gdf_dis, state.cfg.warn_rep, 1'b0};
				RS_STAT: next_state.prdata = {13'h0000, state.flg, state.retry_run,
					state.summary, state.hw_variant};
				RS_MODE: next_state.prdata = {28'h000_0000, state.mode};
				default: next_state.prdata = 32'h0000_0000;
			endcase
		end
		// Writes only while the register port is up
		if (apb_wr && state.serial_en && reg_sel(paddr) == RS_CTRL)
		begin
			next_state.cfg.trip = pwdata[`CTRL_TRIP +: 8];
			next_state.cfg.sel = pwdata[`CTRL_SEL +: 2];
			next_state.cfg.sen_dis = pwdata[`CTRL_SDIS];
			next_state.cfg.gdf_dis = pwdata[`CTRL_GDIS];
			next_state.cfg.warn_rep = pwdata[`CTRL_WREP];
			clear = clear || pwdata[`CTRL_CLR];
		end
		// Clears first so that a same-cycle set wins
		if (clear)
		begin
			if (!sense_hit && !state.retry_run)
			begin
				next_state.flg.sense_oc = 1'b0;
				next_state.flg.sense_stop = 1'b0;
			end
			if (!(|gate_hit_v))
			begin
				next_state.flg.gate_drive_fault = 1'b0;
				next_state.flg.gate_voltage_flags = 6'h00;
			end
			if (!state.flg.tsd_active)
				next_state.flg.tsd_flag = 1'b0;
			if (!vm_uvlo)
				next_state.flg.uvlo = 1'b0;
		end
		// Retry interval counts out, then the retry, sense and phase flags release
		if (state.retry_run)
		begin
			next_state.retry_cnt = state.retry_cnt + `TMR_W'(1);
			if (state.retry_cnt >= RETRY_CYC[`TMR_W-1:0] - `TMR_W'(1))
			begin
				next_state.retry_run = 1'b0;
				next_state.flg.sense_oc = 1'b0;
				next_state.flg.phase_oc = 3'h0;
			end
		end
		// Sense response by mode; no new event during retry
		if (sense_hit && !state.retry_run)
		begin
			case (sel_eff)
				2'h0:
				begin
					next_state.flg.sense_oc = 1'b1;
					next_state.flg.sense_stop = 1'b1;
				end
				2'h1:
				begin
					next_state.flg.sense_oc = 1'b1;
					next_state.flg.phase_oc = sense_hit_v;
					next_state.retry_run = 1'b1;
					next_state.retry_cnt = '0;
				end
				2'h2: next_state.flg.sense_oc = 1'b1;
				default: ;
			endcase
		end
		// Gate fault latch, or full suppression when disabled
		if (gdf_off)
		begin
			next_state.flg.gate_drive_fault = 1'b0;
			next_state.flg.gate_voltage_flags = 6'h00;
		end
		else if (|gate_hit_v)
		begin
			next_state.flg.gate_drive_fault = 1'b1;
			next_state.flg.gate_voltage_flags = state.flg.gate_voltage_flags | gate_hit_v;
		end
		// Thermal warning with hysteresis
		if (temp_warn_over)
			next_state.flg.warn = 1'b1;
		else if (temp_warn_under_hys)
			next_state.flg.warn = 1'b0;
		// Thermal shutdown; no setting can turn it off
		if (temp_sd_over)
		begin
			next_state.flg.tsd_active = 1'b1;
			next_state.flg.tsd_flag = 1'b1;
		end
		else if (temp_sd_under_hys)
			next_state.flg.tsd_active = 1'b0;
		if (vm_uvlo)
			next_state.flg.uvlo = 1'b1;
		// Power mode sequence from the enable pin
		case (state.mode)
			MODE_SLEEP:
				if (enable_eff)
					next_state.mode = MODE_WAKING;
			MODE_WAKING:
				if (!enable_eff)
					next_state.mode = MODE_SLEEP;
				else if (mon_wake && !vm_uvlo)
				begin
					next_state.mode = MODE_OPER;
					next_state.hw_variant = variant_strap;
				end
			MODE_OPER:
				// A short pulse never leaves this mode
				if (mon_past_win)
					next_state.mode = MODE_SHUTDOWN;
			MODE_SHUTDOWN:
				if (enable_eff)
					next_state.mode = MODE_WAKING;
				else if (mon_sleep)
					next_state.mode = MODE_SLEEP;
			default: next_state.mode = MODE_SLEEP;
		endcase
		// Reported faults; warning only when enabled for the pin
		reported = next_state.flg.sense_oc || next_state.flg.gate_drive_fault || next_state.flg.tsd_active
			|| vm_uvlo || (next_state.flg.warn && !next_state.hw_variant
			&& next_state.cfg.warn_rep);
		// Pin also held low while regulators ramp
		next_state.fault_n = !(reported || next_state.mode == MODE_WAKING
			|| next_state.mode == MODE_SHUTDOWN);
		next_state.summary = !next_state.fault_n;
		next_state.drive_en = next_state.mode == MODE_OPER && !vm_uvlo
			&& !next_state.flg.tsd_active && !next_state.flg.sense_stop
			&& !next_state.retry_run && !next_state.flg.gate_drive_fault;
		next_state.gate_drive = next_state.drive_en ? gate_cmd : 6'h00;
		next_state.cp_en = next_state.mode != MODE_SLEEP && !next_state.flg.tsd_active
			&& !vm_uvlo;
		next_state.reg_en = next_state.mode != MODE_SLEEP;
		next_state.serial_en = next_state.mode == MODE_OPER;
		next_state.pulls = next_state.mode == MODE_SLEEP || vm_uvlo;
	end

	// State register; reset lands in sleep with gates pulled off
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state <= '0;
			state.mode <= MODE_SLEEP;
			state.cfg.trip <= `TRIP_RST;
			state.cfg.sel <= `SEL_RST;
			state.pulls <= 1'b1;
			state.fault_n <= 1'b1;
		end
		else
			state <= next_state;
	end

	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign gate_drive = state.gate_drive;
	assign gate_pulls = state.pulls;
	assign charge_pump_en = state.cp_en;
	assign logic_regulator_en = state.reg_en;
	assign serial_en = state.serial_en;
	assign inputs_ready = state.serial_en;
	assign fault_out_n = state.fault_n;
	assign fault_summary = state.summary;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	AST_LATCH_STOP: assert property (
		sense_hit && sel_eff == 2'h0 && !state.retry_run |=> state.flg.sense_oc
		&& !state.drive_en && !state.fault_n ##1 !state.drive_en)
		else $error("latched sense stop missing");
	AST_RETRY_FLAGS: assert property (
		$rose(state.retry_run) |-> state.flg.sense_oc && state.flg.phase_oc != 3'h0
		&& !state.drive_en)
		else $error("retry start without flags");
	AST_REPORT_ONLY: assert property (
		sense_hit && sel_eff == 2'h2 && !state.retry_run |=> state.flg.sense_oc
		&& !state.fault_n)
		else $error("report mode did not report");
	AST_SENSE_IGNORED: assert property (
		sense_off && !state.flg.sense_oc && !state.retry_run && $stable(sense_off)
		|=> !state.flg.sense_oc)
		else $error("disabled sense response acted");
	AST_GATE_STOP: assert property (
		|gate_hit_v |=> state.flg.gate_drive_fault && !state.drive_en && (state.flg.gate_voltage_flags & $past(gate_hit_v))
		== $past(gate_hit_v))
		else $error("gate fault not latched");
	AST_GATE_HOLD: assert property (
		state.flg.gate_drive_fault && !clear && !gdf_off |=> state.flg.gate_drive_fault)
		else $error("gate fault released without clear");
	AST_WARN_PIN: assert property (
		state.flg.warn && state.cfg.warn_rep && !hw |-> !state.fault_n)
		else $error("reported warning not on pin");
	AST_TSD_OFF: assert property (
		temp_sd_over |=> !state.drive_en && !state.cp_en && state.flg.tsd_flag)
		else $error("shutdown left drive on");
	AST_TSD_STICKY: assert property (
		state.flg.tsd_flag && !clear |=> state.flg.tsd_flag)
		else $error("shutdown flag lost");
	AST_TRANSIT_LOW: assert property (
		state.mode == MODE_WAKING |-> !state.fault_n && state.summary)
		else $error("pin released while waking");
endmodule : gate_driver_fault_and_mode_ctrl

// [tb/motor_ctrl_model.sv]
`timescale 1ns/1ps
// Controller side: enable line and power stage gate response
module motor_ctrl_model (
	input wire logic clock, // System clock
	input wire logic [5:0] gate_drive, // Gate drive from the block
	input wire logic [5:0] stuck, // Gates that refuse to turn on
	output logic [5:0] gate_level, // Gate states seen back
	output logic enable_pin // Enable line
);
	initial gate_level = 6'h00;
	initial enable_pin = 1'b0;
	// Gates slew in one cycle; a stuck gate never rises
	always @(posedge clock)
	begin
		gate_level <= gate_drive & ~stuck;
	end
	// Short low pulse, kept inside the reset window
	task reset_pulse(input int n);
		@(posedge clock);
		enable_pin <= 1'b0;
		repeat (n) @(posedge clock);
		enable_pin <= 1'b1;
	endtask : reset_pulse
	// Plain level change of the enable line
	task set_enable(input logic v);
		@(posedge clock);
		enable_pin <= v;
	endtask : set_enable
endmodule : motor_ctrl_model

// [tb/tb_gate_driver_fault_and_mode_ctrl.sv]
`timescale 1ns/1ps
`include "gdrv_defines.svh"
// Compare and count; X never matches
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
// Bounded wait for a level, sampled mid-cycle
`define WAIT(s, v, n) for (int k = 0; k < (n) && (s) !== (v); k++) @(negedge clock);
module tb_gate_driver_fault_and_mode_ctrl;
	logic clock, srst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, cfg;
	logic enable_pin, enable_float, variant_strap, vm_uvlo;
	logic [2:0][7:0] sense_sample; // Per-phase sense codes
	logic [5:0] gate_cmd, gate_level, gate_drive, stuck;
	logic warn_over, warn_hys, sd_over, sd_hys; // Thermal levels
	logic gate_pulls, charge_pump_en, logic_regulator_en, serial_en;
	logic inputs_ready, fault_out_n, fault_summary;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;
	int ph = 0; // Sense phase that trips
	// Short counts so the run stays brief
	gate_driver_fault_and_mode_ctrl #(.RETRY_CYC(50), .SLEEP_CYC(40), .WAKE_CYC(20),
		.RST_WIN_CYC(10)) i_dut (.clock(clock), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
		.enable_float(enable_float), .variant_strap(variant_strap), .vm_uvlo(vm_uvlo),
		.sense_sample(sense_sample), .gate_cmd(gate_cmd), .gate_level(gate_level),
		.temp_warn_over(warn_over), .temp_warn_under_hys(warn_hys),
		.temp_sd_over(sd_over), .temp_sd_under_hys(sd_hys), .gate_drive(gate_drive),
		.gate_pulls(gate_pulls), .charge_pump_en(charge_pump_en),
		.logic_regulator_en(logic_regulator_en), .serial_en(serial_en),
		.inputs_ready(inputs_ready), .fault_out_n(fault_out_n),
		.fault_summary(fault_summary));
	motor_ctrl_model i_ctrl (.clock(clock), .gate_drive(gate_drive), .stuck(stuck),
		.gate_level(gate_level), .enable_pin(enable_pin));
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Hang guard, well above the planned run
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			results;
		end
	end
	// Summary flag must track the pin every cycle
	always @(negedge clock)
		if (!srst) `CHK("summary", ~fault_out_n, fault_summary)
	task results;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	// One transfer; no wait-state count assumed
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] ctrl(input logic [1:0] s, input logic sd, gd, rp);
		return {16'h0000, 8'h80, 2'b00, s, sd, gd, rp, 1'b0};
	endfunction : ctrl
	// Trip phase ph, wait 990 cycles, then drop the sense level once the pin falls or 100 more cycles pass
	task sense_run(input logic [1:0] s, input logic sd);
		cfg = ctrl(s, sd, 1'b0, 1'b0);
		apb(`CTRL_OFS, 1'b1, cfg);
		@(posedge clock) sense_sample[ph] <= 8'hF0;
		repeat (990) @(negedge clock);
		`CHK("deglitch", 1'b1, fault_out_n)
		`WAIT(fault_out_n, 1'b0, 100)
		@(posedge clock) sense_sample[ph] <= 8'h10;
		@(negedge clock);
	endtask : sense_run
	task t_wake;
		`CHK("rst_pulls", 1'b1, gate_pulls)
		apb(`MODE_OFS, 1'b0, 32'h0000_0000);
		`CHK("mode_sleep", 32'h0000_0001, rd)
		i_ctrl.set_enable(1'b1);
		`WAIT(fault_out_n, 1'b0, 5)
		`CHK("wake_low", 1'b0, fault_out_n)
		`WAIT(inputs_ready, 1'b1, 40)
		`CHK("ready", 1'b1, inputs_ready)
		`CHK("wake_rel", 1'b1, fault_out_n)
		`CHK("pump", 2'b11, {charge_pump_en, logic_regulator_en})
		apb(8'h0C, 1'b0, 32'h0000_0000);
		`CHK("unmapped", 1'b1, err)
		apb(`CTRL_OFS, 1'b0, 32'h0000_0000);
		`CHK("ctrl_rst", 32'h0000_8000, rd)
	endtask : t_wake
	task t_sense;
		sense_run(2'b00, 1'b0);
		`CHK("s00_drive", 6'h00, gate_drive)
		apb(`STAT_OFS, 1'b0, 32'h0000_0000);
		`CHK("s00_flag", 1'b1, rd[4])
		repeat (60) @(negedge clock);
		`CHK("s00_held", 1'b0, fault_out_n)
		apb(`CTRL_OFS, 1'b1, cfg | 32'h0000_0001);
		`WAIT(fault_out_n, 1'b1, 5)
		`CHK("s00_clr", gate_cmd, gate_drive)
		ph = 1;
		sense_run(2'b01, 1'b0);
		apb(`STAT_OFS, 1'b0, 32'h0000_0000);
		`CHK("s01_phase", 3'b010, rd[12:10])
		ph = 0;
		repeat (35) @(negedge clock);
		`CHK("s01_hold", 1'b0, fault_out_n)
		`WAIT(fault_out_n, 1'b1, 30)
		`CHK("s01_retry", gate_cmd, gate_drive)
		sense_run(2'b10, 1'b0);
		`CHK("s10_fault", 1'b0, fault_out_n)
		`CHK("s10_drive", gate_cmd, gate_drive)
		i_ctrl.reset_pulse(5);
		`WAIT(fault_out_n, 1'b1, 10)
		`CHK("pulse_clr", 1'b1, fault_out_n)
		`CHK("pulse_ser", 1'b1, serial_en)
		apb(`CTRL_OFS, 1'b0, 32'h0000_0000);
		`CHK("pulse_cfg", cfg, rd)
		sense_run(2'b11, 1'b0);
		`CHK("s11", 1'b1, fault_out_n)
		sense_run(2'b00, 1'b1);
		`CHK("sdis", 1'b1, fault_out_n)
	endtask : t_sense
	task t_gate;
		cfg = ctrl(2'b00, 1'b0, 1'b0, 1'b0);
		apb(`CTRL_OFS, 1'b1, cfg);
		@(posedge clock) stuck <= 6'h01;
		`WAIT(fault_out_n, 1'b0, 1100)
		`CHK("gdf_off", 6'h00, gate_drive)
		apb(`STAT_OFS, 1'b0, 32'h0000_0000);
		`CHK("gdf_flags", 2'b11, {rd[5], rd[13]})
		@(posedge clock) stuck <= 6'h00;
		apb(`CTRL_OFS, 1'b1, cfg | 32'h0000_0001);
		`WAIT(fault_out_n, 1'b1, 5)
		`CHK("gdf_clr", gate_cmd, gate_drive)
		cfg = ctrl(2'b00, 1'b0, 1'b1, 1'b0);
		apb(`CTRL_OFS, 1'b1, cfg);
		@(posedge clock) stuck <= 6'h01;
		repeat (1100) @(negedge clock);
		`CHK("gdf_dis", 1'b1, fault_out_n)
		@(posedge clock) stuck <= 6'h00;
	endtask : t_gate
	task t_therm;
		@(posedge clock) {warn_over, warn_hys, gate_cmd} <= {2'b10, 6'h2A};
		apb(`STAT_OFS, 1'b0, 32'h0000_0000);
		`CHK("warn_flag", 1'b1, rd[8])
		`CHK("warn_quiet", {gate_cmd, 1'b1}, {gate_drive, fault_out_n})
		apb(`CTRL_OFS, 1'b1, ctrl(2'b00, 1'b0, 1'b0, 1'b1));
		`WAIT(fault_out_n, 1'b0, 5)
		`CHK("warn_rep", 1'b0, fault_out_n)
		@(posedge clock) {warn_over, warn_hys} <= 2'b01;
		`WAIT(fault_out_n, 1'b1, 5)
		`CHK("warn_gone", 1'b1, fault_out_n)
		@(posedge clock) {sd_over, sd_hys} <= 2'b10;
		`WAIT(fault_out_n, 1'b0, 5)
		`CHK("tsd", 7'h00, {gate_drive, charge_pump_en})
		@(posedge clock) {sd_over, sd_hys} <= 2'b01;
		`WAIT(fault_out_n, 1'b1, 5)
		apb(`STAT_OFS, 1'b0, 32'h0000_0000);
		`CHK("tsd_sticky", 2'b11, {rd[7], fault_out_n})
		apb(`CTRL_OFS, 1'b1, 32'h0000_8001);
		apb(`STAT_OFS, 1'b0, 32'h0000_0000);
		`CHK("tsd_clr", 1'b0, rd[7])
	endtask : t_therm
	task t_sleep;
		i_ctrl.set_enable(1'b0);
		`WAIT(fault_out_n, 1'b0, 20)
		`CHK("down_low", 1'b0, fault_out_n)
		`WAIT(gate_pulls, 1'b1, 60)
		`CHK("sleep", 9'h100, {gate_pulls, serial_en, logic_regulator_en, gate_drive})
		@(posedge clock) {variant_strap, enable_float} <= 2'b11;
		`WAIT(inputs_ready, 1'b1, 40)
		`CHK("float_wake", 1'b1, inputs_ready)
		ph = 2;
		sense_run(2'b00, 1'b0);
		`CHK("pin_trip", 1'b0, fault_out_n)
		apb(`STAT_OFS, 1'b0, 32'h0000_0000);
		`CHK("pin_phase", 3'b100, rd[12:10])
		`WAIT(fault_out_n, 1'b1, 60)
		`CHK("pin_retry", 1'b1, fault_out_n)
		@(posedge clock) vm_uvlo <= 1'b1;
		`WAIT(gate_pulls, 1'b1, 5)
		`CHK("uvlo", 7'h40, {gate_pulls, gate_drive})
	endtask : t_sleep
	initial
	begin
		{srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0000_0000};
		{enable_float, variant_strap, vm_uvlo, stuck} = 9'h000;
		sense_sample = '0;
		gate_cmd = 6'h15;
		{warn_over, warn_hys, sd_over, sd_hys} = 4'h5;
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		t_wake;
		t_sense;
		t_gate;
		t_therm;
		t_sleep;
		results;
	end
endmodule : tb_gate_driver_fault_and_mode_ctrl
